// ===== rtl/operand_bus_master_port.v
// Bus master port of the operand bus: arbitration handshake and cycle strobes.
// Assumes a core on the same clock posts cycle requests and holds them
// until done; pin inputs arrive asynchronously and are synchronised here.
`include "opbus_consts.vh"

// Notes on behaviour
// - Request bus low while needing ownership.
// - Test mode low floats bus request.
// - Take bus only after grant seen.
// - No ownership taken while busy asserted.
// - Acknowledge low while owning the bus.
// - Release acknowledge by floating, not high.
// - Fetch cycles drive operand flag low.
// - Wait for transfer acknowledge to finish.
// - Ack tied low means no wait states.
// - Memory select high memory, low I/O.
// - Direction high read, low write; float.
// - Address strobe marks address; float otherwise.
// - Data strobe marks data; float otherwise.
// - Test mode floats every output.
module operand_bus_master_port (
    input  wire MCLK,
    input  wire SRST,
    // Core side, same clock.
    input  wire CYC_REQ,
    input  wire CYC_MEM,
    input  wire CYC_READ,
    input  wire CYC_OPERAND,
    input  wire CYC_LAST,
    output wire CYC_DONE,
    output wire BUS_OWNED,
    // Pin inputs, asynchronous, active low.
    input  wire TEST_N,
    input  wire BUS_GRANT_IN_N,
    input  wire BUSY_IN_N,
    input  wire TRANSFER_ACK_IN_N,
    // Three-state pin outputs.
    output wire BUS_REQUEST_N_O,
    output wire BUS_REQUEST_N_OE,
    output wire MASTER_ACK_OUT_N_O,
    output wire MASTER_ACK_OUT_N_OE,
    output wire MEM_NOT_IO_O,
    output wire MEM_NOT_IO_OE,
    output wire READ_NOT_WRITE_O,
    output wire READ_NOT_WRITE_OE,
    output wire OPERAND_NOT_FETCH_O,
    output wire OPERAND_NOT_FETCH_OE,
    output wire ADDR_VALID_STROBE_N_O,
    output wire ADDR_VALID_STROBE_N_OE,
    output wire DATA_VALID_STROBE_N_O,
    output wire DATA_VALID_STROBE_N_OE
);

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    wire [3:0] pins_sync;
    wire       test_mode;
    wire       grant_seen;
    wire       busy_seen;
    wire       xfer_ack;

    pin_sync #(
        .WIDTH    (4)
    ) u_sync (
        .clk      (MCLK),
        .rst      (SRST),
        .async_in ({TEST_N, BUS_GRANT_IN_N, BUSY_IN_N, TRANSFER_ACK_IN_N}),
        .sync_out (pins_sync)
    );

    // Reset loads high levels, so test mode and grant read inactive at start.
    assign test_mode  = ~pins_sync[3];
    assign grant_seen = ~pins_sync[2];
    assign busy_seen  = ~pins_sync[1];
    assign xfer_ack   = ~pins_sync[0];

    // ------------------------------------------------------------------------
    // State and registered outputs
    // ------------------------------------------------------------------------
    reg [`ARB_W-1:0] arb_reg;
    reg [`ARB_W-1:0] arb_next;
    reg [`CYC_W-1:0] cyc_reg;
    reg [`CYC_W-1:0] cyc_next;
    reg              req_n_reg;
    reg              req_n_next;
    reg              own_reg;
    reg              own_next;
    reg              mem_reg;
    reg              mem_next;
    reg              read_reg;
    reg              read_next;
    reg              opnd_reg;
    reg              opnd_next;
    reg              as_n_reg;
    reg              as_n_next;
    reg              ds_n_reg;
    reg              ds_n_next;
    reg              last_reg;
    reg              last_next;
    reg              done_reg;
    reg              done_next;

    // ------------------------------------------------------------------------
    // Arbitration machine
    // ------------------------------------------------------------------------
    // Ownership is held across back-to-back cycles until the core marks the
    // last one; re-arbitrating per cycle would cost a grant round trip each.
    always @* begin
        arb_next   = arb_reg;
        req_n_next = req_n_reg;
        own_next   = own_reg;
        case (arb_reg)
            `ARB_IDLE: begin
                if (CYC_REQ && !test_mode) begin
                    req_n_next = 1'b0;
                    arb_next   = `ARB_REQ;
                end
            end
            `ARB_REQ: begin
                // Grant is honoured only while no other master holds busy.
                if (grant_seen && !busy_seen) begin
                    own_next   = 1'b1;
                    req_n_next = 1'b1;
                    arb_next   = `ARB_OWN;
                end
            end
            `ARB_OWN: begin
                if (cyc_reg == `CYC_END && last_reg) begin
                    arb_next = `ARB_DONE;
                end
            end
            `ARB_DONE: begin
                own_next = 1'b0;
                arb_next = `ARB_IDLE;
            end
            default: begin
                arb_next   = `ARB_IDLE;
                req_n_next = 1'b1;
                own_next   = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Bus cycle machine
    // ------------------------------------------------------------------------
    // Strobes only start once acknowledge has been driven for a cycle, so
    // the owner mark is visible before any control line moves.
    always @* begin
        cyc_next  = cyc_reg;
        mem_next  = mem_reg;
        read_next = read_reg;
        opnd_next = opnd_reg;
        as_n_next = as_n_reg;
        ds_n_next = ds_n_reg;
        last_next = last_reg;
        done_next = 1'b0;
        case (cyc_reg)
            `CYC_IDLE: begin
                if (own_reg && arb_reg == `ARB_OWN && CYC_REQ) begin
                    mem_next  = CYC_MEM;
                    read_next = CYC_READ;
                    opnd_next = CYC_OPERAND;
                    last_next = CYC_LAST;
                    as_n_next = `STROBE_ON;
                    cyc_next  = `CYC_ADDR;
                end
            end
            `CYC_ADDR: begin
                ds_n_next = `STROBE_ON;
                cyc_next  = `CYC_DATA;
            end
            `CYC_DATA: begin
                // With acknowledge tied low this state lasts one cycle.
                if (xfer_ack) begin
                    as_n_next = `STROBE_OFF;
                    ds_n_next = `STROBE_OFF;
                    done_next = 1'b1;
                    cyc_next  = `CYC_END;
                end
            end
            `CYC_END: begin
                opnd_next = `KIND_OPERAND;
                cyc_next  = `CYC_IDLE;
            end
            default: begin
                cyc_next  = `CYC_IDLE;
                as_n_next = `STROBE_OFF;
                ds_n_next = `STROBE_OFF;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    // Test mode forces everything back to idle; a cycle cut short is lost,
    // which matches the need for a master reset around test mode.
    always @(posedge MCLK) begin
        if (SRST || test_mode) begin
            arb_reg   <= `ARB_IDLE;
            cyc_reg   <= `CYC_IDLE;
            req_n_reg <= 1'b1;
            own_reg   <= 1'b0;
            mem_reg   <= `KIND_MEM;
            read_reg  <= `KIND_READ;
            opnd_reg  <= `KIND_OPERAND;
            as_n_reg  <= `STROBE_OFF;
            ds_n_reg  <= `STROBE_OFF;
            last_reg  <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            arb_reg   <= arb_next;
            cyc_reg   <= cyc_next;
            req_n_reg <= req_n_next;
            own_reg   <= own_next;
            mem_reg   <= mem_next;
            read_reg  <= read_next;
            opnd_reg  <= opnd_next;
            as_n_reg  <= as_n_next;
            ds_n_reg  <= ds_n_next;
            last_reg  <= last_next;
            done_reg  <= done_next;
        end
    end

    assign CYC_DONE  = done_reg;
    assign BUS_OWNED = own_reg;

    // ------------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------------
    // Request is driven whenever not in test mode; ownership pins only
    // while the acknowledge is held.
    wire req_drive;
    wire own_drive;

    assign req_drive = ~test_mode;
    assign own_drive = own_reg & ~test_mode;

    tri_pin u_req (
        .drive_en (req_drive),
        .value_in (req_n_reg),
        .pin_o    (BUS_REQUEST_N_O),
        .pin_oe   (BUS_REQUEST_N_OE)
    );

    // Acknowledge is driven low only, never high: release means float.
    tri_pin u_ack (
        .drive_en (own_drive),
        .value_in (1'b0),
        .pin_o    (MASTER_ACK_OUT_N_O),
        .pin_oe   (MASTER_ACK_OUT_N_OE)
    );

    tri_pin u_mem (
        .drive_en (own_drive),
        .value_in (mem_reg),
        .pin_o    (MEM_NOT_IO_O),
        .pin_oe   (MEM_NOT_IO_OE)
    );

    tri_pin u_dir (
        .drive_en (own_drive),
        .value_in (read_reg),
        .pin_o    (READ_NOT_WRITE_O),
        .pin_oe   (READ_NOT_WRITE_OE)
    );

    tri_pin u_opnd (
        .drive_en (own_drive),
        .value_in (opnd_reg),
        .pin_o    (OPERAND_NOT_FETCH_O),
        .pin_oe   (OPERAND_NOT_FETCH_OE)
    );

    tri_pin u_as (
        .drive_en (own_drive),
        .value_in (as_n_reg),
        .pin_o    (ADDR_VALID_STROBE_N_O),
        .pin_oe   (ADDR_VALID_STROBE_N_OE)
    );

    tri_pin u_ds (
        .drive_en (own_drive),
        .value_in (ds_n_reg),
        .pin_o    (DATA_VALID_STROBE_N_O),
        .pin_oe   (DATA_VALID_STROBE_N_OE)
    );

endmodule // operand_bus_master_port

// ===== rtl/opbus_consts.vh
// Constants for the operand bus master port: state codes, cycle kinds, timing.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef OPBUS_CONSTS_VH
`define OPBUS_CONSTS_VH

// ----------------------------------------------------------------------------
// Arbiter state codes (one-hot)
// ----------------------------------------------------------------------------
`define ARB_IDLE      4'h1
`define ARB_REQ       4'h2
`define ARB_OWN       4'h4
`define ARB_DONE      4'h8
`define ARB_W         4

// ----------------------------------------------------------------------------
// Bus cycle state codes (one-hot)
// ----------------------------------------------------------------------------
`define CYC_IDLE      4'h1
`define CYC_ADDR      4'h2
`define CYC_DATA      4'h4
`define CYC_END       4'h8
`define CYC_W         4

// ----------------------------------------------------------------------------
// Polarity of the cycle kind inputs and of idle outputs
// ----------------------------------------------------------------------------
`define KIND_MEM      1'h1
`define KIND_READ     1'h1
`define KIND_OPERAND  1'h1
`define STROBE_OFF    1'h1
`define STROBE_ON     1'h0

// ----------------------------------------------------------------------------
// Synchroniser depth
// ----------------------------------------------------------------------------
`define SYNC_STAGES   2

`endif

// ===== rtl/pin_sync.v
// Two flip-flop synchroniser for a vector of asynchronous pin inputs.
// Assumes one clock; reset loads the inactive (high) level of each pin.
module pin_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------------------
    // Two stages
    // ------------------------------------------------------------------------
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] stable_reg;

    // The first stage feeds only the second, so metastability cannot spread.
    always @(posedge clk) begin
        if (rst) begin
            meta_reg   <= {WIDTH{1'b1}};
            stable_reg <= {WIDTH{1'b1}};
        end else begin
            meta_reg   <= async_in;
            stable_reg <= meta_reg;
        end
    end

    assign sync_out = stable_reg;

endmodule // pin_sync

// ===== rtl/tri_pin.v
// Output stage of a three-state pin: value and enable, no high impedance here.
// Assumes the pad or bench resolves the wire from the enable.
module tri_pin (
    input  wire drive_en,
    input  wire value_in,
    output wire pin_o,
    output wire pin_oe
);

    // ------------------------------------------------------------------------
    // Gated drive
    // ------------------------------------------------------------------------
    // The value is forced high when not driving so a floating pin never
    // shows a stale active level to a bench that ignores the enable.
    assign pin_o  = drive_en ? value_in : 1'b1;
    assign pin_oe = drive_en;

endmodule // tri_pin

// ===== dv/opbus_far_side.sv
// Far side of the operand bus: arbiter, one other master and the addressed memory.
// Assumes resolved pin levels from the bench; released lines read high.
module opbus_far_side (
    input  wire        clk,
    input  wire        srst,
    input  wire        req_n,
    input  wire        own_n,
    input  wire        ds_n,
    input  wire        busy_on,
    input  wire        ack_tied,
    input  wire  [1:0] ack_wait,
    output logic       grant_n,
    output wire        busy_n,
    output wire        transfer_ack_in_n_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt_reg;
    logic       ack_reg;

    // Grant follows the request and is held until ownership is acknowledged.
    always @(posedge clk) begin
        if (srst || !own_n) begin
            grant_n <= 1'b1;
        end else if (!req_n) begin
            grant_n <= 1'b0;
        end
    end

    // The other master claims the bus only while this device is not the owner.
    assign busy_n = !(busy_on && own_n);

    // Acknowledge after a chosen wait and hold it until the data strobe goes.
    always @(posedge clk) begin
        if (srst || ds_n) begin
            cnt_reg <= 2'h0;
            ack_reg <= 1'b1;
        end else if (cnt_reg == ack_wait) begin
            ack_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 2'h1;
        end
    end
    assign transfer_ack_in_n_n = ack_tied ? 1'b0 : ack_reg;
endmodule // opbus_far_side

// ===== dv/opbus_chk.sv
// Checker of the operand bus master port, bound to its top module.
// Assumes pin inputs change only shortly after the rising clock edge.
module opbus_chk (
    input wire MCLK, SRST, CYC_REQ, CYC_DONE, BUS_OWNED, TEST_N,
    input wire BUS_GRANT_IN_N, BUSY_IN_N, TRANSFER_ACK_IN_N,
    input wire BUS_REQUEST_N_O, BUS_REQUEST_N_OE, MASTER_ACK_OUT_N_O,
    input wire MASTER_ACK_OUT_N_OE, MEM_NOT_IO_OE, READ_NOT_WRITE_OE,
    input wire OPERAND_NOT_FETCH_O, OPERAND_NOT_FETCH_OE,
    input wire ADDR_VALID_STROBE_N_O, ADDR_VALID_STROBE_N_OE,
    input wire DATA_VALID_STROBE_N_O, DATA_VALID_STROBE_N_OE
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);

    // ------------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------------
    property p_req_float; (!TEST_N)[*4] |-> !BUS_REQUEST_N_OE; endproperty
    a_req_float: assert property (p_req_float)
        else $error("request still driven in test mode");
    property p_req_take;
        $rose(CYC_REQ) && BUS_REQUEST_N_O && !MASTER_ACK_OUT_N_OE && TEST_N
            |-> ##[1:3] !BUS_REQUEST_N_O;
    endproperty
    a_req_take: assert property (p_req_take)
        else $error("no bus request after cycle request");
    property p_own_grant; $rose(BUS_OWNED) |-> !$past(BUS_GRANT_IN_N, 3); endproperty
    a_own_grant: assert property (p_own_grant)
        else $error("ownership taken without grant");
    property p_own_busy; $rose(BUS_OWNED) |-> $past(BUSY_IN_N, 3); endproperty
    a_own_busy: assert property (p_own_busy)
        else $error("ownership taken while busy");
    property p_ack_low; MASTER_ACK_OUT_N_OE |-> !MASTER_ACK_OUT_N_O; endproperty
    a_ack_low: assert property (p_ack_low)
        else $error("acknowledge driven high");

    // ------------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------------
    property p_strobe_owned;
        !ADDR_VALID_STROBE_N_O && ADDR_VALID_STROBE_N_OE
            |-> !MASTER_ACK_OUT_N_O && MASTER_ACK_OUT_N_OE && BUS_REQUEST_N_O;
    endproperty
    a_strobe_owned: assert property (p_strobe_owned)
        else $error("strobe without acknowledge");
    property p_float_all;
        !MEM_NOT_IO_OE |-> !(READ_NOT_WRITE_OE || OPERAND_NOT_FETCH_OE ||
            ADDR_VALID_STROBE_N_OE || DATA_VALID_STROBE_N_OE);
    endproperty
    a_float_all: assert property (p_float_all)
        else $error("cycle line driven while not owner");
    property p_done_ack;
        CYC_DONE |-> !$past(TRANSFER_ACK_IN_N, 2) || !$past(TRANSFER_ACK_IN_N, 3);
    endproperty
    a_done_ack: assert property (p_done_ack)
        else $error("cycle done without acknowledge");
    property p_zero_wait;
        (!TRANSFER_ACK_IN_N)[*4] ##0 $fell(ADDR_VALID_STROBE_N_O)
            |-> ##1 !DATA_VALID_STROBE_N_O ##1 CYC_DONE;
    endproperty
    a_zero_wait: assert property (p_zero_wait)
        else $error("wait state with acknowledge tied low");
    property p_fetch_end; CYC_DONE |=> OPERAND_NOT_FETCH_O; endproperty
    a_fetch_end: assert property (p_fetch_end)
        else $error("fetch flag held after cycle");
endmodule // opbus_chk

bind operand_bus_master_port opbus_chk chk_u (.*);

// ===== dv/operand_bus_master_port_test.sv
// Self-checking bench of the operand bus master port with its far side.
// Assumes pins released by the port are pulled high on the board.
module operand_bus_master_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic MCLK, SRST, CYC_REQ, CYC_MEM, CYC_READ, CYC_OPERAND, CYC_LAST, TEST_N;
    wire  CYC_DONE, BUS_OWNED, BUS_GRANT_IN_N, BUSY_IN_N, TRANSFER_ACK_IN_N;
    wire  BUS_REQUEST_N_O, BUS_REQUEST_N_OE, MASTER_ACK_OUT_N_O, MASTER_ACK_OUT_N_OE;
    wire  MEM_NOT_IO_O, MEM_NOT_IO_OE, READ_NOT_WRITE_O, READ_NOT_WRITE_OE;
    wire  OPERAND_NOT_FETCH_O, OPERAND_NOT_FETCH_OE;
    wire  ADDR_VALID_STROBE_N_O, ADDR_VALID_STROBE_N_OE;
    wire  DATA_VALID_STROBE_N_O, DATA_VALID_STROBE_N_OE;
    logic busy_on, ack_tied;
    logic [1:0] ack_wait;
    integer seed, err_total, tests_run, i, r;
    wire req_pin = BUS_REQUEST_N_OE ? BUS_REQUEST_N_O : 1'b1;
    wire own_pin = MASTER_ACK_OUT_N_OE ? MASTER_ACK_OUT_N_O : 1'b1;
    wire ds_pin  = DATA_VALID_STROBE_N_OE ? DATA_VALID_STROBE_N_O : 1'b1;
    wire [6:0] oes = {BUS_REQUEST_N_OE, MASTER_ACK_OUT_N_OE, MEM_NOT_IO_OE,
        READ_NOT_WRITE_OE, OPERAND_NOT_FETCH_OE, ADDR_VALID_STROBE_N_OE,
        DATA_VALID_STROBE_N_OE};

    operand_bus_master_port dut_u (.*);
    opbus_far_side far_u (.clk(MCLK), .srst(SRST), .req_n(req_pin), .own_n(own_pin),
        .ds_n(ds_pin), .busy_on(busy_on), .ack_tied(ack_tied), .ack_wait(ack_wait),
        .grant_n(BUS_GRANT_IN_N), .busy_n(BUSY_IN_N), .transfer_ack_in_n_n(TRANSFER_ACK_IN_N));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Kind lines seen on the bus: memory, read and operand flags in order.
    function automatic [2:0] exp_kind(input logic [3:0] k);
        exp_kind = k[3:1];
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // One core cycle; k is {mem, read, operand, last}, w the acknowledge wait.
    task automatic run_cycle(input logic [3:0] k, input logic [1:0] w);
        integer n;
        logic [2:0] seen;
        @(posedge MCLK);
        #2;
        seen = 3'bxxx;
        n = 0;
        ack_wait = w;
        {CYC_MEM, CYC_READ, CYC_OPERAND, CYC_LAST} = k;
        CYC_REQ = 1'b1;
        while (CYC_DONE !== 1'b1 && n < 200) begin
            @(posedge MCLK);
            #2;
            n = n + 1;
            if (ADDR_VALID_STROBE_N_OE === 1'b1 && ADDR_VALID_STROBE_N_O === 1'b0)
                seen = {MEM_NOT_IO_O, READ_NOT_WRITE_O, OPERAND_NOT_FETCH_O};
        end
        CYC_REQ = 1'b0;
        chk({7'h0, CYC_DONE}, 8'h01);
        chk({5'h0, seen}, {5'h0, exp_kind(k)});
        if (k[0]) begin
            n = 0;
            while (BUS_OWNED !== 1'b0 && n < 8) begin
                @(posedge MCLK);
                #2;
                n = n + 1;
            end
            chk({1'b0, oes}, 8'h40);
        end
    endtask

    // The clock toggles every half period of 10 ns.
    initial begin
        MCLK = 1'b0;
        forever #10 MCLK = ~MCLK;
    end

    // A hang ends the run through the same verdict.
    initial begin
        repeat (20000) @(posedge MCLK);
        err_total = err_total + 1;
        print_verdict;
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 32'hbe6df17d;
        err_total = 0;
        tests_run = 0;
        {SRST, TEST_N, CYC_REQ, CYC_MEM, CYC_READ, CYC_OPERAND, CYC_LAST} = 7'h60;
        {busy_on, ack_tied, ack_wait} = 4'h0;
        repeat (16) @(posedge MCLK);
        #2 SRST = 1'b0;
        chk({1'b0, oes}, 8'h40);
        // Another master holds the bus, so ownership must wait for it.
        busy_on = 1'b1;
        {CYC_MEM, CYC_READ, CYC_OPERAND, CYC_LAST, CYC_REQ} = 5'h1f;
        repeat (10) @(posedge MCLK);
        #2;
        chk({7'h0, BUS_OWNED}, 8'h00);
        chk({7'h0, BUS_REQUEST_N_O}, 8'h00);
        busy_on = 1'b0;
        run_cycle(4'hf, 2'd3);
        // Fetch, I/O and write cycles back to back under one ownership.
        run_cycle(4'b0010, 2'd0);
        run_cycle(4'b1000, 2'd1);
        run_cycle(4'b0101, 2'd2);
        ack_tied = 1'b1;
        run_cycle(4'b1110, 2'd0);
        run_cycle(4'b1011, 2'd0);
        ack_tied = 1'b0;
        for (i = 0; i < 24; i = i + 1) begin
            r = $random(seed);
            run_cycle(r[3:0], r[5:4]);
        end
        run_cycle(4'b1001, 2'd1);
        // Test mode floats every output until a reset follows.
        TEST_N = 1'b0;
        repeat (6) @(posedge MCLK);
        #2;
        chk({1'b0, oes}, 8'h00);
        {TEST_N, SRST} = 2'b11;
        repeat (3) @(posedge MCLK);
        #2 SRST = 1'b0;
        chk({1'b0, oes}, 8'h40);
        run_cycle(4'b1101, 2'd1);
        print_verdict;
    end
endmodule // operand_bus_master_port_test
